// [include/coef_bank_map.svh]
// register map constants for the equalizer fir coefficient bank
`ifndef COEF_BANK_MAP_SVH
`define COEF_BANK_MAP_SVH
// printed offsets are indexes; byte address is four times the index
`define CHAN_A_TAP8_IDX 12'h427
`define CHAN_A_TAP9_IDX 12'h429
`define CHAN_B_TAP1_IDX 12'h448
`define CHAN_B_TAP2_IDX 12'h44a
`define CHAN_B_TAP3_IDX 12'h44c
// own register: bit 0 selects dual-channel mode
`define MODE_CTRL_IDX 12'h4f0
`define COEF_MSB 11
`define RSVD_MSB 15
`define RSVD_LSB 12
`define OUTER_COEF_W 12
`define CENTER_COEF_W 18
`define REG_W 16
`define COEF_RESET 16'h0000
`define MODE_RESET 1'b0
`endif

// [include/coef_bank_pkg.sv]
// types for the equalizer fir coefficient bank
package coef_bank_pkg;
  typedef struct packed {
    logic [11:0] tap8;
    logic [11:0] tap9;
  } chan_a_taps_s;
  typedef struct packed {
    logic [11:0] tap1;
    logic [11:0] tap2;
    logic [11:0] tap3;
  } chan_b_taps_s;
  typedef logic [15:0] coef_word_t;
endpackage

// [src/coef_word_reg.sv]
// one 16-bit coefficient register with sign-masked readback
`timescale 1ns/10ps
`include "coef_bank_map.svh"
module coef_word_reg (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // write side
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  // stored value and readback view
  output coef_bank_pkg::coef_word_t value,
  output logic [15:0] rd_view
);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      value <= `COEF_RESET;
    end else if (wr_en) begin
      value <= wr_data;
    end
  end
  // top coefficient bit never returns on read
  always_comb begin
    rd_view = value;
    rd_view[`COEF_MSB] = 1'b0;
  end
endmodule

// [src/coef_bank.sv]
// apb register bank holding outer fir coefficients for taps a8, a9, b1-b3
//
// Local design decision: register access over APB.
`timescale 1ns/10ps
`include "coef_bank_map.svh"
module coef_bank (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // filter side
  output logic dual_mode,
  output coef_bank_pkg::chan_a_taps_s chan_a_taps,
  output coef_bank_pkg::chan_b_taps_s chan_b_taps
);
  localparam int NREG = 5;
  localparam logic [11:0] IDX [NREG] = '{`CHAN_A_TAP8_IDX, `CHAN_A_TAP9_IDX,
    `CHAN_B_TAP1_IDX, `CHAN_B_TAP2_IDX, `CHAN_B_TAP3_IDX};

  // elaboration-time width check, outer field must end at the masked msb
  if (`OUTER_COEF_W != `COEF_MSB + 1 || `CENTER_COEF_W <= `OUTER_COEF_W) begin : g_bad_width
    $error("coefficient widths inconsistent");
  end

  logic setup;
  logic [11:0] idx;
  logic aligned;
  logic [NREG-1:0] hit;
  logic mode_hit;
  logic [15:0] vals [NREG];
  logic [15:0] views [NREG];
  logic [15:0] rd_mux;
  logic mapped;

  // single-cycle access: answer registered at setup, pready high in access
  assign setup = psel && !penable;
  assign idx = paddr[13:2];
  assign aligned = paddr[1:0] == 2'b00 && paddr[15:14] == 2'b00;
  assign mode_hit = aligned && idx == `MODE_CTRL_IDX;

  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_reg
      assign hit[g] = aligned && idx == IDX[g];
      coef_word_reg u_reg (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(psel && penable && pwrite && hit[g]),
        .wr_data(pwdata[15:0]),
        .value(vals[g]),
        .rd_view(views[g])
      );
    end
  endgenerate

  always_comb begin
    rd_mux = 16'h0000;
    mapped = mode_hit;
    if (mode_hit) begin
      rd_mux = {15'h0000, dual_mode};
    end
    for (int i = 0; i < NREG; i++) begin
      if (hit[i]) begin
        rd_mux = views[i];
        mapped = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= (setup && !pwrite) ? {16'h0000, rd_mux} : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dual_mode <= `MODE_RESET;
    end else if (psel && penable && pwrite && mode_hit) begin
      dual_mode <= pwdata[0];
    end
  end

  // taps registered so the filter sees flop outputs; channel b zeroed when single
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      chan_a_taps <= '0;
      chan_b_taps <= '0;
    end else begin
      chan_a_taps.tap8 <= vals[0][`COEF_MSB:0];
      chan_a_taps.tap9 <= vals[1][`COEF_MSB:0];
      chan_b_taps.tap1 <= dual_mode ? vals[2][`COEF_MSB:0] : 12'h000;
      chan_b_taps.tap2 <= dual_mode ? vals[3][`COEF_MSB:0] : 12'h000;
      chan_b_taps.tap3 <= dual_mode ? vals[4][`COEF_MSB:0] : 12'h000;
    end
  end

  sign_hidden_a: assert property (@(posedge clk) disable iff (!rst_n)
    (setup && !pwrite && mapped) |=> prdata[`COEF_MSB] == 1'b0)
    else $error("coefficient sign bit leaked on read");
  tap8_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 chan_a_taps.tap8 == $past(vals[0][`COEF_MSB:0]))
    else $error("tap8 output not following register");
  tap9_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 chan_a_taps.tap9 == $past(vals[1][`COEF_MSB:0]))
    else $error("tap9 output not following register");
  b1_dual_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(dual_mode) |-> chan_b_taps.tap1 == $past(vals[2][`COEF_MSB:0]))
    else $error("b tap1 wrong in dual mode");
  b2_dual_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(dual_mode) |-> chan_b_taps.tap2 == $past(vals[3][`COEF_MSB:0]))
    else $error("b tap2 wrong in dual mode");
  b3_dual_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(dual_mode) |-> chan_b_taps.tap3 == $past(vals[4][`COEF_MSB:0]))
    else $error("b tap3 wrong in dual mode");
  single_mute_a: assert property (@(posedge clk) disable iff (!rst_n)
    !dual_mode ##1 !dual_mode |-> chan_b_taps == '0)
    else $error("channel b active in single mode");
  write_store_a: assert property (@(posedge clk) disable iff (!rst_n)
    (psel && penable && pwrite && hit[0]) |=> vals[0] == $past(pwdata[15:0]))
    else $error("write not stored");
  reset_zero_a: assert property (@(posedge clk)
    !rst_n |=> vals[0] == 16'h0000 && vals[4] == 16'h0000)
    else $error("register not zero after reset");
endmodule

// [sim/tb.sv]
// self-checking bench for the coefficient bank
`timescale 1ns/10ps
`include "coef_bank_map.svh"
module tb;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, dual_mode, err, dual;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd, d;
  coef_bank_pkg::chan_a_taps_s chan_a_taps;
  coef_bank_pkg::chan_b_taps_s chan_b_taps;
  logic [15:0] mem [5];
  logic [15:0] adr [5];
  int error_cnt = 0, check_count = 0, seed = 80, i, k;
  localparam logic [15:0] MODE_ADDR = {2'b00, `MODE_CTRL_IDX, 2'b00};
  coef_bank i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dual_mode(dual_mode), .chan_a_taps(chan_a_taps),
    .chan_b_taps(chan_b_taps));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // readback hides the field's top bit only
  function automatic logic [31:0] rb(input logic [15:0] w);
    return {16'h0000, w & 16'hf7ff};
  endfunction
  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; waits on pready under a bound
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) error_cnt++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so the next call never re-drives psel in this time step
    @(posedge clk);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #(3000 * 25);
    error_cnt++;
    results();
  end
  initial begin
    adr = '{{2'b00, `CHAN_A_TAP8_IDX, 2'b00}, {2'b00, `CHAN_A_TAP9_IDX, 2'b00},
      {2'b00, `CHAN_B_TAP1_IDX, 2'b00}, {2'b00, `CHAN_B_TAP2_IDX, 2'b00},
      {2'b00, `CHAN_B_TAP3_IDX, 2'b00}};
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 5; i++) begin
      apb(1'b0, adr[i], 32'h0);
      check(rd, 40'h0);
    end
    for (k = 0; k < 8; k++) begin
      // corner words first: all ones, sign bit alone
      for (i = 0; i < 5; i++) begin
        d = (k == 0) ? 32'hffffffff : (k == 1) ? 32'h00000800 : $random(seed);
        mem[i] = d[15:0];
        apb(1'b1, adr[i], d);
      end
      dual = (k > 1) ? 1'($random(seed)) : k[0];
      apb(1'b1, MODE_ADDR, {31'h0, dual});
      for (i = 0; i < 5; i++) begin
        apb(1'b0, adr[i], 32'h0);
        check(rd, rb(mem[i]));
      end
      apb(1'b0, MODE_ADDR, 32'h0);
      check(rd, {31'h0, dual});
      repeat (2) @(posedge clk);
      check(dual_mode, dual);
      check(chan_a_taps, {mem[0][11:0], mem[1][11:0]});
      if (dual) check(chan_b_taps, {mem[2][11:0], mem[3][11:0], mem[4][11:0]});
      else check(chan_b_taps, 40'h0);
    end
    // refused accesses leave the bank untouched
    apb(1'b1, adr[2] + 16'h0001, 32'h00001234);
    check(err, 1'b1);
    apb(1'b0, 16'hc000 | adr[2], 32'h0);
    check({err, rd}, {1'b1, 32'h0});
    apb(1'b0, adr[2], 32'h0);
    check({err, rd}, {1'b0, rb(mem[2])});
    results();
  end
endmodule
